// ---- logic/cbs_pkg.sv ----
/*
  Shared constants and types for the bit timing and synchronisation block:
  bus levels, segment states, the timing configuration bundle and the
  per-bit event bundle.
  Assumes the bit stream logic that uses these types runs on the same clock.
*/

package cbs_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int PRESC_W = 5;
  localparam int SEG_W = 3;
  localparam int JW_W = 2;
  localparam int CNT_W = 5;
  localparam int ERR_W = 6;

  // ==========================================================================
  // Bus levels
  // ==========================================================================
  localparam logic RECESSIVE = 1'b1;
  localparam logic DOMINANT = 1'b0;

  // ==========================================================================
  // Reset values and fixed lengths
  // ==========================================================================
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [CNT_W-1:0] ONE_TQ = 5'h01;
  localparam logic [CNT_W-1:0] SYNC_SEG_TQ = 5'h01;
  localparam logic [PRESC_W-1:0] PRESC_RST = 5'h00;
  localparam logic [ERR_W-1:0] ERR_RST = 6'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    SEG_SYNC,
    SEG_ONE,
    SEG_TWO
  } cbs_seg_e;

  // Each field holds its length minus one: in quanta for segments and jump width, in clocks for the prescaler
  typedef struct packed {
    logic [PRESC_W-1:0] quantum_prescaler_m1;
    logic [SEG_W-1:0] prop_seg_m1;
    logic [SEG_W-1:0] phase_buffer_one_m1;
    logic [SEG_W-1:0] phase_buffer_two_m1;
    logic [JW_W-1:0] jump_width_m1;
  } cbs_timing_s;

  typedef struct packed {
    logic sample;
    logic bit_value;
    logic bit_start;
    logic hard_sync;
    logic resync;
  } cbs_event_s;

endpackage

// ---- logic/cbs_prescaler.sv ----
/*
  Time quantum prescaler: one tick every (quantum_prescaler_m1 + 1) clocks.
  Assumes the divisor is held stable while the controller is active.
*/

`timescale 1ns/1ns

module cbs_prescaler #(
  parameter int PRESC_W = cbs_pkg::PRESC_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Divisor, programmed value minus one
  input wire logic [PRESC_W-1:0] quantum_prescaler_m1_i,
  // One clock pulse per quantum
  output logic tq_tick_o
);

  // ==========================================================================
  // Divider
  // ==========================================================================
  logic [PRESC_W-1:0] div_cnt_r;

  // Decoded from the count, so the first quantum after reset is no longer than the rest
  assign tq_tick_o = (div_cnt_r >= quantum_prescaler_m1_i);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_r <= '0;
    end else if (tq_tick_o) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + PRESC_W'(1);
    end
  end

endmodule

// ---- logic/cbs_bit_timing.sv ----
/*
  Bit timing and synchronisation logic of a CAN protocol controller.
  Counts quanta through sync, first and second segments, samples the bus
  once per bit, and hard- or re-synchronises on recessive-to-dominant edges.
  Assumes rx_i is synchronous to sys_clk_i, and that the bit stream logic
  raises hard_sync_en_i while a new frame may start (bus idle).
*/


`timescale 1ns/1ns

module cbs_bit_timing #(
  parameter int PRESC_W = cbs_pkg::PRESC_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire cbs_pkg::cbs_timing_s timing_i,
  // Bit stream control
  input wire logic hard_sync_en_i,
  input wire logic tx_bit_i,
  // Bus side
  input wire logic rx_i,
  output logic tx_o,
  // Events and status
  output cbs_pkg::cbs_event_s event_o,
  output logic [cbs_pkg::ERR_W-1:0] phase_error_o,
  output cbs_pkg::cbs_seg_e segment_o
);

  // ==========================================================================
  // Quantum tick
  // ==========================================================================
  logic tq_tick;

  cbs_prescaler #(
    .PRESC_W(PRESC_W)
  ) u_prescaler (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .quantum_prescaler_m1_i(timing_i.quantum_prescaler_m1[PRESC_W-1:0]),
    .tq_tick_o(tq_tick)
  );

  // ==========================================================================
  // Nominal lengths in quanta
  // ==========================================================================
  localparam int CW = cbs_pkg::CNT_W;

  logic [CW-1:0] prop_len;
  logic [CW-1:0] one_len;
  logic [CW-1:0] two_len;
  logic [CW-1:0] jw_req;
  logic [CW-1:0] jw_len;
  logic [CW-1:0] len1;

  // Fields are length minus one, so every length is at least one quantum
  assign prop_len = {2'b00, timing_i.prop_seg_m1} + cbs_pkg::ONE_TQ;
  assign one_len = {2'b00, timing_i.phase_buffer_one_m1} + cbs_pkg::ONE_TQ;
  assign two_len = {2'b00, timing_i.phase_buffer_two_m1} + cbs_pkg::ONE_TQ;
  assign jw_req = {3'b000, timing_i.jump_width_m1} + cbs_pkg::ONE_TQ;

  // Clamped so a bad setting cannot shrink a buffer below zero
  always_comb begin
    jw_len = jw_req;
    if (jw_len > one_len) begin
      jw_len = one_len;
    end
    if (jw_len > two_len) begin
      jw_len = two_len;
    end
  end

  // Sample point sits after propagation plus first buffer
  assign len1 = prop_len + one_len;

  // ==========================================================================
  // State registers
  // ==========================================================================
  cbs_pkg::cbs_seg_e seg_r;
  cbs_pkg::cbs_seg_e seg_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] extra_r;
  logic [CW-1:0] extra_nxt;
  logic [CW-1:0] shrink_r;
  logic [CW-1:0] shrink_nxt;
  logic skip_r;
  logic skip_nxt;
  logic prev_sample_r;
  logic synced_r;
  logic hs_done_r;

  // ==========================================================================
  // Edge detection and phase error
  // ==========================================================================
  logic edge_seen;
  logic do_hard;
  logic do_resync;
  logic [CW-1:0] cnt_inc;
  logic [CW-1:0] late_err;
  logic [CW-1:0] early_mag;
  logic [CW-1:0] ext_late;
  logic [CW-1:0] shr_early;
  logic [cbs_pkg::ERR_W-1:0] err_val;

  // Single sample per quantum straight from the pin, no filter delay
  assign edge_seen = tq_tick && (prev_sample_r == cbs_pkg::RECESSIVE)
                     && (rx_i == cbs_pkg::DOMINANT)
                     && !synced_r;

  assign do_hard = edge_seen && hard_sync_en_i && !hs_done_r;
  assign do_resync = edge_seen && !do_hard;

  assign cnt_inc = cnt_r + cbs_pkg::ONE_TQ;

  // Late: quanta since the end of sync; early: quanta left before next sync
  assign late_err = cnt_inc;
  assign early_mag = two_len - cnt_r;

  // Capped corrections; any excess stays in the bit
  assign ext_late = (late_err < jw_len) ? late_err : jw_len;
  assign shr_early = (early_mag < jw_len) ? early_mag : jw_len;

  always_comb begin
    err_val = cbs_pkg::ERR_RST;
    unique case (seg_r)
      cbs_pkg::SEG_SYNC: begin
        err_val = cbs_pkg::ERR_RST;
      end
      cbs_pkg::SEG_ONE: begin
        err_val = {1'b0, late_err};
      end
      cbs_pkg::SEG_TWO: begin
        err_val = 6'(-{1'b0, early_mag});
      end
    endcase
  end

  // ==========================================================================
  // Segment sequencer
  // ==========================================================================
  logic sample_now;
  logic bit_start_now;

  always_comb begin
    seg_nxt = seg_r;
    cnt_nxt = cnt_r;
    extra_nxt = extra_r;
    shrink_nxt = shrink_r;
    skip_nxt = skip_r;
    sample_now = 1'b0;
    bit_start_now = 1'b0;
    if (tq_tick) begin
      if (do_hard) begin
        // Edge quantum becomes the sync quantum of a fresh bit
        seg_nxt = cbs_pkg::SEG_ONE;
        cnt_nxt = cbs_pkg::CNT_RST;
        extra_nxt = cbs_pkg::CNT_RST;
        shrink_nxt = cbs_pkg::CNT_RST;
        skip_nxt = 1'b0;
        bit_start_now = 1'b1;
      end else begin
        unique case (seg_r)
          cbs_pkg::SEG_SYNC: begin
            // One quantum only; an edge here needs no correction
            seg_nxt = cbs_pkg::SEG_ONE;
            cnt_nxt = cbs_pkg::CNT_RST;
          end
          cbs_pkg::SEG_ONE: begin
            if (do_resync) begin
              extra_nxt = ext_late;
            end
            if (cnt_inc >= len1 + extra_nxt) begin
              seg_nxt = cbs_pkg::SEG_TWO;
              cnt_nxt = cbs_pkg::CNT_RST;
              sample_now = 1'b1;
            end else begin
              cnt_nxt = cnt_inc;
            end
          end
          cbs_pkg::SEG_TWO: begin
            if (do_resync) begin
              shrink_nxt = shr_early;
              skip_nxt = 1'b1;
            end
            if (cnt_inc >= two_len - shrink_nxt) begin
              // Skipping sync: the last quantum of the buffer, the edge quantum within jump width, is redefined as sync
              seg_nxt = skip_nxt ? cbs_pkg::SEG_ONE : cbs_pkg::SEG_SYNC;
              cnt_nxt = cbs_pkg::CNT_RST;
              extra_nxt = cbs_pkg::CNT_RST;
              shrink_nxt = cbs_pkg::CNT_RST;
              skip_nxt = 1'b0;
              bit_start_now = 1'b1;
            end else begin
              cnt_nxt = cnt_inc;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_r <= cbs_pkg::SEG_SYNC;
      cnt_r <= cbs_pkg::CNT_RST;
      extra_r <= cbs_pkg::CNT_RST;
      shrink_r <= cbs_pkg::CNT_RST;
      skip_r <= 1'b0;
    end else begin
      seg_r <= seg_nxt;
      cnt_r <= cnt_nxt;
      extra_r <= extra_nxt;
      shrink_r <= shrink_nxt;
      skip_r <= skip_nxt;
    end
  end

  // ==========================================================================
  // Sample level and synchronisation bookkeeping
  // ==========================================================================
  // Reference level for edge detection moves only at sample points
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_sample_r <= cbs_pkg::RECESSIVE;
    end else if (sample_now) begin
      prev_sample_r <= rx_i;
    end
  end

  // Sample point opens a new window for one synchronisation
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      synced_r <= 1'b0;
    end else if (sample_now) begin
      synced_r <= 1'b0;
    end else if (edge_seen) begin
      synced_r <= 1'b1;
    end
  end

  // Rearmed only once the bit stream logic drops the enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_done_r <= 1'b0;
    end else if (do_hard) begin
      hs_done_r <= 1'b1;
    end else if (!hard_sync_en_i) begin
      hs_done_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Transmit path
  // ==========================================================================
  // Receive path stays live while driving, for arbitration and acknowledge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_o <= cbs_pkg::RECESSIVE;
    end else if (bit_start_now) begin
      tx_o <= tx_bit_i;
    end
  end

  // ==========================================================================
  // Event and status outputs
  // ==========================================================================
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_o <= '0;
      event_o.bit_value <= cbs_pkg::RECESSIVE;
    end else begin
      event_o.sample <= sample_now;
      event_o.bit_start <= bit_start_now;
      event_o.hard_sync <= do_hard;
      event_o.resync <= do_resync;
      if (sample_now) begin
        event_o.bit_value <= rx_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_error_o <= cbs_pkg::ERR_RST;
    end else if (edge_seen) begin
      phase_error_o <= err_val;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      segment_o <= cbs_pkg::SEG_SYNC;
    end else begin
      segment_o <= seg_nxt;
    end
  end

endmodule

// ---- verif/cbs_bus_node.sv ----
/*
  Far node on the bus, standing in for the other nodes behind a transceiver.
  Assumes the bench changes node_dom_i just after rising clock edges.
*/

`timescale 1ns/1ns

module cbs_bus_node (
  // Drive levels
  input wire logic tx_i,
  input wire logic node_dom_i,
  // Bus level seen by the block
  output logic rx_o
);
  // ==========================================================================
  // Wired-AND bus
  // ==========================================================================
  // Pull-up keeps the line recessive once both parties release it
  assign rx_o = tx_i & ~node_dom_i;
endmodule

// ---- verif/cbs_bit_timing_chk.sv ----
/*
  Concurrent checks on the ports of the bit timing block.
  Assumes one clock domain and timing held stable while out of reset.
*/

`timescale 1ns/1ns

module cbs_bit_timing_chk #(
  parameter int PRESC_W = cbs_pkg::PRESC_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire cbs_pkg::cbs_timing_s timing_i,
  input wire logic hard_sync_en_i,
  input wire logic tx_bit_i,
  input wire logic rx_i,
  input wire logic tx_o,
  input wire cbs_pkg::cbs_event_s event_o,
  input wire logic [cbs_pkg::ERR_W-1:0] phase_error_o,
  input wire cbs_pkg::cbs_seg_e segment_o
);
  logic [5:0] sync_len_r;
  logic sync_seen_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Six bits, since a quantum may span 32 clocks
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_len_r <= 6'h00;
    end else begin
      sync_len_r <= (segment_o == cbs_pkg::SEG_SYNC) ? sync_len_r + 6'h01 : 6'h00;
    end
  end

  // Sample pulse wins over a sync in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_seen_r <= 1'b0;
    end else if (event_o.sample) begin
      sync_seen_r <= 1'b0;
    end else if (event_o.resync || event_o.hard_sync) begin
      sync_seen_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_sync_len;
    segment_o == cbs_pkg::SEG_SYNC |-> sync_len_r <= {1'b0, timing_i.quantum_prescaler_m1};
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync segment too long");

  property p_one_sync;
    (event_o.resync || event_o.hard_sync) && !event_o.sample |-> !sync_seen_r;
  endproperty
  a_one_sync: assert property (p_one_sync) else $error("second sync before sample");

  property p_edge_cond;
    event_o.resync || event_o.hard_sync |->
      $past(rx_i) == cbs_pkg::DOMINANT && $past(event_o.bit_value) == cbs_pkg::RECESSIVE;
  endproperty
  a_edge_cond: assert property (p_edge_cond) else $error("sync without falling edge");

  property p_bit_value;
    event_o.sample |-> event_o.bit_value == $past(rx_i);
  endproperty
  a_bit_value: assert property (p_bit_value) else $error("sampled level wrong");

  property p_hard;
    event_o.hard_sync |-> event_o.bit_start && !event_o.resync && segment_o == cbs_pkg::SEG_ONE;
  endproperty
  a_hard: assert property (p_hard) else $error("hard sync restart wrong");

  property p_err_sync;
    event_o.resync && $past(segment_o) == cbs_pkg::SEG_SYNC |-> phase_error_o == cbs_pkg::ERR_RST;
  endproperty
  a_err_sync: assert property (p_err_sync) else $error("edge in sync not zero error");

  property p_err_late;
    event_o.resync && $past(segment_o) == cbs_pkg::SEG_ONE |->
      !phase_error_o[5] && phase_error_o != cbs_pkg::ERR_RST;
  endproperty
  a_err_late: assert property (p_err_late) else $error("late edge error not positive");

  property p_err_early;
    event_o.resync && $past(segment_o) == cbs_pkg::SEG_TWO |->
      phase_error_o[5] && segment_o != cbs_pkg::SEG_SYNC ##1 (segment_o != cbs_pkg::SEG_SYNC) [*2];
  endproperty
  a_err_early: assert property (p_err_early) else $error("early edge handling wrong");

  property p_sample_pt;
    event_o.sample |-> $past(segment_o) == cbs_pkg::SEG_ONE && segment_o == cbs_pkg::SEG_TWO;
  endproperty
  a_sample_pt: assert property (p_sample_pt) else $error("sample not at end of first buffer");

  property p_tx;
    $changed(tx_o) |-> event_o.bit_start;
  endproperty
  a_tx: assert property (p_tx) else $error("drive changed outside bit start");

  c_hard: cover property (event_o.hard_sync);
  c_late: cover property (event_o.resync && $past(segment_o) == cbs_pkg::SEG_ONE);
  c_early: cover property (event_o.resync && $past(segment_o) == cbs_pkg::SEG_TWO);
endmodule

bind cbs_bit_timing cbs_bit_timing_chk #(.PRESC_W(PRESC_W)) chk_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .timing_i(timing_i), .hard_sync_en_i(hard_sync_en_i), .tx_bit_i(tx_bit_i), .rx_i(rx_i), .tx_o(tx_o),
  .event_o(event_o), .phase_error_o(phase_error_o), .segment_o(segment_o));

// ---- verif/tb_can_bit_synchronizer.sv ----
/*
  Self-checking bench for the bit timing block with a far node on the bus.
  Assumes segments of 2, 3 and 3 quanta and a jump width of 2 unless reset.
*/

`timescale 1ns/1ns

module tb_can_bit_synchronizer;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  cbs_pkg::cbs_timing_s timing = 16'h0000;
  logic hs_en = 1'b0;
  logic tx_bit = 1'b1;
  logic node_dom = 1'b0;
  logic rx;
  logic tx;
  cbs_pkg::cbs_event_s ev;
  logic [5:0] perr;
  cbs_pkg::cbs_seg_e seg;
  int errors = 0;
  int check_count = 0;

  always #50 sys_clk = ~sys_clk;

  cbs_bus_node node_u (.tx_i(tx), .node_dom_i(node_dom), .rx_o(rx));

  cbs_bit_timing dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .timing_i(timing), .hard_sync_en_i(hs_en),
    .tx_bit_i(tx_bit), .rx_i(rx), .tx_o(tx), .event_o(ev), .phase_error_o(perr), .segment_o(seg));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic restart(input logic [4:0] presc);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    node_dom <= 1'b0;
    timing <= '{presc, 3'h1, 3'h2, 3'h2, 2'h1};
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Edge placed in a bit with a recessive sample before it; counts clocks to two samples
  task automatic edge_run(input int d, input int err, input int s1e, input int s2e, input bit glitch);
    int n;
    int s1;
    int syncs;
    int hards;
    n = 0;
    s1 = 0;
    syncs = 0;
    hards = 0;
    repeat (2) begin
      @(negedge sys_clk);
      for (int i = 0; i < 400 && ev.bit_start !== 1'b1; i++) @(negedge sys_clk);
    end
    while (n < 40) begin
      @(posedge sys_clk);
      if (n == d) node_dom <= 1'b1;
      if (glitch && n == d + 1) node_dom <= 1'b0;
      if (glitch && n == d + 2) node_dom <= 1'b1;
      @(negedge sys_clk);
      n++;
      syncs += int'(ev.resync);
      hards += int'(ev.hard_sync);
      if (ev.sample === 1'b1 && s1 != 0) break;
      if (ev.sample === 1'b1) s1 = n;
    end
    @(posedge sys_clk);
    node_dom <= 1'b0;
    check("first sample", s1, s1e);
    check("second sample", n, s2e);
    check("sync count", syncs, 1);
    check("hard sync inside frame", hards, 0);
    check("phase error", perr, err[5:0]);
  endtask

  // Edge in the second buffer with hard sync armed restarts the bit
  task automatic hard_sync_run();
    int n;
    n = 0;
    @(negedge sys_clk);
    for (int i = 0; i < 20 && seg !== cbs_pkg::SEG_TWO; i++) @(negedge sys_clk);
    @(posedge sys_clk);
    hs_en <= 1'b1;
    node_dom <= 1'b1;
    @(negedge sys_clk);
    for (int i = 0; i < 40 && ev.hard_sync !== 1'b1; i++) @(negedge sys_clk);
    check("bit start on hard sync", ev.bit_start, 1'b1);
    check("segment after hard sync", seg, cbs_pkg::SEG_ONE);
    while (ev.sample !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    check("hard sync to sample", n, 5);
    @(posedge sys_clk);
    node_dom <= 1'b0;
  endtask

  // Bus still read while this node drives
  task automatic tx_run(input logic drv, input logic other);
    @(posedge sys_clk);
    tx_bit <= drv;
    node_dom <= other;
    repeat (2) begin
      @(negedge sys_clk);
      for (int i = 0; i < 400 && ev.sample !== 1'b1; i++) @(negedge sys_clk);
    end
    check("own drive", tx, drv);
    check("level received", ev.bit_value, cbs_pkg::DOMINANT);
  endtask

  // Nine quanta a bit, each quanta presc+1 clocks
  task automatic quantum_run(input logic [4:0] m1);
    int n;
    n = 0;
    restart(m1);
    @(negedge sys_clk);
    for (int i = 0; i < 900 && ev.sample !== 1'b1; i++) @(negedge sys_clk);
    do begin
      @(negedge sys_clk);
      n++;
    end while (ev.sample !== 1'b1 && n < 900);
    check("bit length in clocks", n, 9 * (m1 + 1));
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    restart(5'h00);
    hard_sync_run();
    edge_run(0, 1, 7, 16, 1'b1);
    edge_run(1, 2, 8, 17, 1'b0);
    edge_run(4, 5, 8, 17, 1'b0);
    edge_run(5, -3, 6, 12, 1'b0);
    edge_run(6, -2, 6, 13, 1'b0);
    edge_run(7, -1, 6, 14, 1'b0);
    edge_run(8, 0, 6, 15, 1'b0);
    tx_run(1'b0, 1'b0);
    tx_run(1'b1, 1'b1);
    quantum_run(5'h1f);
    quantum_run(5'h02);
    quantum_run(5'h00);
    tally_and_finish();
  end

  // Whole run needs under 5000 clocks
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end
endmodule
